// File: hdl/ssp_core.v
// Serial port core: clock-synchronous or UART transmit and receive with enable control.
// Assumes pins arrive asynchronously and are resynchronised here; software sets the
// enables as plain level inputs on the system clock.
`include "ssp_regs.vh"

module ssp_core #(
  parameter DIV_W = `SSP_DIV_W
) (
  input  wire                   clock,                    // System clock, 125 MHz.
  input  wire                   rst,                      // Synchronous reset.
  input  wire                   sio_en,                   // Serial port enable.
  input  wire                   tx_en,                    // Transmit enable.
  input  wire                   rx_en,                    // Receive enable.
  input  wire                   sync_mode,                // 1 synchronous, 0 UART.
  input  wire                   ext_clk_sel,              // 1 external shift clock.
  input  wire                   rdy_out_en,               // Ready output enable.
  input  wire [DIV_W-1:0]       baud_div,                 // Half-period divider minus one.
  input  wire                   err_clr,                  // Clears framing error.
  input  wire                   tx_valid,                 // Transmit byte offered.
  input  wire [`SSP_DATA_W-1:0] tx_data,                  // Transmit byte.
  output wire                   tx_ready,                 // FIFO accepts a byte.
  output reg                    rx_valid,                 // Received byte pulse.
  output reg  [`SSP_DATA_W-1:0] rx_data,                  // Received byte.
  output reg                    frame_err,                // Sticky UART stop error.
  output reg                    tx_shift_done,            // Transmit shift complete.
  output reg                    tx_buf_empty,             // Transmit buffer empty.
  input  wire                   rxd_pin,                  // Receive data pin.
  input  wire                   sclk_pin,                 // Shift clock pin input.
  output reg                    sclk_out,                 // Shift clock pin output.
  output reg                    sclk_oe,                  // Shift clock pin enable.
  output reg                    txd_out,                  // Transmit pin output.
  output reg                    txd_oe,                   // Transmit pin enable.
  output reg                    serial_receive_ready_out, // Receiver ready level.
  output reg                    serial_receive_ready_out_oe                   // Ready pin enable.
);

  localparam RX_IDLE  = 2'b00;
  localparam RX_START = 2'b01;
  localparam RX_DATA  = 2'b10;
  localparam RX_STOP  = 2'b11;

  reg                   rxd_s1, rxd_s2;
  reg                   sclk_s1, sclk_s2, sclk_s3;
  reg                   mode_sync_r, mode_ext_r;
  reg [DIV_W-1:0]       div_r, rxdiv_r;
  reg [`SSP_DATA_W-1:0] buf_r;
  reg                   buf_full_r;
  reg [9:0]             tx_sh_r;
  reg                   tx_busy_r, sclk_r, htog_r;
  reg [3:0]             tx_cnt_r;
  reg [1:0]             clr_cnt_r;
  reg [1:0]             rx_st_r;
  reg [2:0]             rx_cnt_r;
  reg                   rx_ph_r;
  reg [`SSP_DATA_W-1:0] rx_sh_r;
  wire                  f_valid;
  wire [`SSP_DATA_W-1:0] f_data;
  wire                  f_take;
  wire                  half_tick, rx_tick;
  wire                  tx_active, sync_ext;
  wire                  sfall, srise, edge_ev;
  wire                  load_ok, tx_end;
  wire                  rx_run_sync;

  ssp_fifo #(
    .WIDTH (`SSP_DATA_W),
    .DEPTH (`SSP_FIFO_DEPTH),
    .AW    (3)
  ) u_fifo (
    .clock     (clock),
    .rst       (rst),
    .in_valid  (tx_valid),
    .in_data   (tx_data),
    .in_ready  (tx_ready),
    .out_valid (f_valid),
    .out_data  (f_data),
    .out_ready (f_take)
  );

  always @(posedge clock)
  begin
    if (rst)
    begin
      rxd_s1  <= 1'b1;
      rxd_s2  <= 1'b1;
      sclk_s1 <= 1'b1;
      sclk_s2 <= 1'b1;
      sclk_s3 <= 1'b1;
    end
    else
    begin
      rxd_s1  <= rxd_pin;
      rxd_s2  <= rxd_s1;
      sclk_s1 <= sclk_pin;
      sclk_s2 <= sclk_s1;
      sclk_s3 <= sclk_s2;
    end
  end

  // Mode is taken from the inputs only while both directions are off.
  always @(posedge clock)
  begin
    if (rst)
    begin
      mode_sync_r <= 1'b0;
      mode_ext_r  <= 1'b0;
    end
    else if (~tx_en & ~rx_en)                                          // R11
    begin
      mode_sync_r <= sync_mode;                                          // R14
      mode_ext_r  <= ext_clk_sel;
    end
  end

  assign sync_ext  = mode_sync_r & mode_ext_r;
  assign tx_active = tx_en | (mode_sync_r & rx_en);                    // R5 R9
  assign half_tick = (div_r == baud_div);
  assign rx_tick   = (rxdiv_r == baud_div);
  // One shift clock serves both directions in synchronous mode.
  assign sfall     = mode_ext_r ? (sclk_s3 & ~sclk_s2)                  // R8
                                : (half_tick & tx_busy_r & sclk_r);
  assign srise     = mode_ext_r ? (~sclk_s3 & sclk_s2)
                                : (half_tick & tx_busy_r & ~sclk_r);
  assign edge_ev   = mode_sync_r ? (sfall | srise) : (half_tick & htog_r);
  assign f_take    = ~buf_full_r & tx_active;
  assign load_ok   = buf_full_r & ~tx_busy_r & tx_active               // R3
                     & (~sync_ext | sclk_s2);                            // R13
  assign tx_end    = tx_busy_r & (mode_sync_r ? (srise & (tx_cnt_r[2:0] == `SSP_SYNC_LAST))
                                              : (half_tick & htog_r & (tx_cnt_r == `SSP_UART_LAST)));
  assign rx_run_sync = sio_en & rx_en;                                   // R6

  always @(posedge clock)
  begin
    if (rst | half_tick)
      div_r <= {DIV_W{1'b0}};
    else
      div_r <= div_r + 1'b1;
  end

  // Transmitter; the port enable plays no part here, only the transmit activity.
  always @(posedge clock)
  begin
    if (rst)
    begin
      buf_r      <= {`SSP_DATA_W{1'b0}};
      buf_full_r <= 1'b0;
      tx_sh_r    <= 10'h3ff;
      tx_busy_r  <= 1'b0;
      sclk_r     <= `SSP_SCLK_IDLE;
      htog_r     <= 1'b0;
      tx_cnt_r   <= 4'h0;
    end
    else if (~tx_active)                                                 // R5
    begin
      buf_full_r <= 1'b0;
      tx_busy_r  <= 1'b0;
      sclk_r     <= `SSP_SCLK_IDLE;
      htog_r     <= 1'b0;
      tx_cnt_r   <= 4'h0;
    end
    else
    begin
      if (f_take & f_valid)
      begin
        buf_r      <= f_data;
        buf_full_r <= 1'b1;
      end
      if (load_ok)                                                       // R1 R3
      begin
        buf_full_r <= 1'b0;
        tx_busy_r  <= 1'b1;
        tx_cnt_r   <= 4'h0;
        htog_r     <= 1'b0;
        tx_sh_r    <= mode_sync_r ? {2'b11, buf_r} : {1'b1, buf_r, 1'b0};
      end
      else if (tx_busy_r & mode_sync_r)
      begin
        if (half_tick & ~mode_ext_r)
          sclk_r <= ~sclk_r;
        if (sfall & (tx_cnt_r != 4'h0))
          tx_sh_r <= {1'b1, tx_sh_r[9:1]};
        if (tx_end)
          tx_busy_r <= 1'b0;
        else if (srise)
          tx_cnt_r <= tx_cnt_r + 1'b1;
      end
      else if (tx_busy_r & half_tick)
      begin
        htog_r <= ~htog_r;
        if (tx_end)
          tx_busy_r <= 1'b0;
        else if (htog_r)
        begin
          tx_sh_r  <= {1'b1, tx_sh_r[9:1]};
          tx_cnt_r <= tx_cnt_r + 1'b1;
        end
      end
    end
  end

  // Completion flag falls on the second shift-clock edge after a buffer write.
  always @(posedge clock)
  begin
    if (rst)
    begin
      clr_cnt_r     <= 2'h0;
      tx_shift_done <= `SSP_TX_DONE_RST;
    end
    else
    begin
      if (f_take & f_valid)
        clr_cnt_r <= `SSP_DONE_EDGES;                                    // R12
      else if (edge_ev & (clr_cnt_r != 2'h0))
        clr_cnt_r <= clr_cnt_r - 1'b1;
      if ((tx_end & ~buf_full_r) | ~tx_active)
        tx_shift_done <= 1'b1;
      else if (edge_ev & (clr_cnt_r == 2'h1))
        tx_shift_done <= 1'b0;                                           // R12
    end
  end

  // Receiver for both modes.
  always @(posedge clock)
  begin
    if (rst)
    begin
      rx_st_r   <= RX_IDLE;
      rx_cnt_r  <= 3'h0;
      rx_ph_r   <= 1'b0;
      rx_sh_r   <= {`SSP_DATA_W{1'b0}};
      rxdiv_r   <= {DIV_W{1'b0}};
      rx_valid  <= 1'b0;
      rx_data   <= {`SSP_DATA_W{1'b0}};
      frame_err <= 1'b0;
    end
    else
    begin
      rx_valid <= 1'b0;
      if (err_clr)
        frame_err <= 1'b0;
      rxdiv_r <= (rx_tick | (rx_st_r == RX_IDLE)) ? {DIV_W{1'b0}} : rxdiv_r + 1'b1;
      if (mode_sync_r)
      begin
        rx_st_r <= RX_IDLE;
        if (~rx_run_sync)                                                // R6
          rx_cnt_r <= 3'h0;
        else if (srise)                                                  // R8
        begin
          rx_sh_r  <= {rxd_s2, rx_sh_r[7:1]};
          rx_cnt_r <= rx_cnt_r + 1'b1;
          if (rx_cnt_r == `SSP_SYNC_LAST)
          begin
            rx_valid <= 1'b1;
            rx_data  <= {rxd_s2, rx_sh_r[7:1]};
          end
        end
      end
      else if (~rx_en)                                                   // R7
        rx_st_r <= RX_IDLE;
      else
      begin
        case (rx_st_r)
          RX_IDLE:
            if (~rxd_s2)
              rx_st_r <= RX_START;
          RX_START:
            if (rx_tick)
            begin
              rx_st_r  <= rxd_s2 ? RX_IDLE : RX_DATA;
              rx_ph_r  <= 1'b0;
              rx_cnt_r <= 3'h0;
            end
          RX_DATA:
            if (rx_tick)
            begin
              rx_ph_r <= ~rx_ph_r;
              if (rx_ph_r)
              begin
                rx_sh_r  <= {rxd_s2, rx_sh_r[7:1]};
                rx_cnt_r <= rx_cnt_r + 1'b1;
                if (rx_cnt_r == `SSP_SYNC_LAST)
                  rx_st_r <= RX_STOP;
              end
            end
          default:
            if (rx_tick)
            begin
              rx_ph_r <= ~rx_ph_r;
              if (rx_ph_r)
              begin
                rx_st_r  <= RX_IDLE;
                rx_valid <= 1'b1;
                rx_data  <= rx_sh_r;
                if (~rxd_s2)
                  frame_err <= 1'b1;
              end
            end
        endcase
      end
    end
  end

  // Pin stage; with the port disabled the pins are released to port use.
  always @(posedge clock)
  begin
    if (rst)
    begin
      txd_out                  <= `SSP_TXD_IDLE;
      txd_oe                   <= 1'b0;
      sclk_out                 <= `SSP_SCLK_IDLE;
      sclk_oe                  <= 1'b0;
      serial_receive_ready_out_oe                  <= 1'b0;
      serial_receive_ready_out <= 1'b0;
      tx_buf_empty             <= 1'b1;
    end
    else
    begin
      txd_out  <= (sio_en & tx_busy_r) ? tx_sh_r[0] : `SSP_TXD_IDLE;   // R2 R4
      txd_oe   <= sio_en;                                                // R2
      sclk_out <= sclk_r;
      sclk_oe  <= sio_en & mode_sync_r & ~mode_ext_r;                    // R2
      serial_receive_ready_out_oe  <= sio_en & sync_ext & rx_en & rdy_out_en & tx_en;        // R10
      serial_receive_ready_out <= sio_en & sync_ext & rx_en & rdy_out_en // R10
                                  & tx_en & (rx_cnt_r == 3'h0);
      tx_buf_empty <= ~buf_full_r;
    end
  end

endmodule

// File: hdl/ssp_regs.vh
// Constants for the serial port core: field widths, bit counts and reset values.
// Assumes inclusion by the serial port core and its FIFO only.
//
// Contract
// R1: Clearing the port enable neither stops nor clears a running transmit shift.
// R2: With the port disabled, the pins are released and shifted bits stay internal.
// R3: A buffer write while the transmitter is active loads and shifts, even when disabled.
// R4: Enabling the port mid-byte puts the remaining bits on the transmit pin.
// R5: Only clearing transmit enable stops and resets the transmitter; in synchronous mode the code keeps it running while receive enable is set.
// R6: In synchronous mode, clearing receive enable or port enable stops reception.
// R7: In UART mode, clearing receive enable stops reception.
// R8: In synchronous mode both directions share one shift clock.
// R9: In synchronous mode, receive enable keeps the transmit clock circuit running.
// R10: Ready output drives only with receive, ready-output and transmit enables all set.
// R11: Mode settings take effect only after both transmit and receive are disabled.
// R12: Completion flag falls 0.5 to 1.5 shift clocks after a buffer write.
// R13: With external clock, buffer loads happen only while the clock input is high.
// R14: Exactly one mode, synchronous or UART, is active, chosen by a mode input.
`ifndef SSP_REGS_VH
`define SSP_REGS_VH

`define SSP_DATA_W        8
`define SSP_FIFO_DEPTH    8
`define SSP_DIV_W         12
`define SSP_SYNC_LAST     3'h7
`define SSP_UART_LAST     4'h9
`define SSP_DONE_EDGES    2'h2
`define SSP_TX_DONE_RST   1'b1
`define SSP_TXD_IDLE      1'b1
`define SSP_SCLK_IDLE     1'b1

`endif

// File: hdl/ssp_fifo.v
// Synchronous FIFO with valid and ready on both sides.
// Assumes one clock and a synchronous active-high reset.
`include "ssp_regs.vh"

module ssp_fifo #(
  parameter WIDTH = `SSP_DATA_W,
  parameter DEPTH = `SSP_FIFO_DEPTH,
  parameter AW    = 3
) (
  input  wire             clock,     // System clock.
  input  wire             rst,       // Synchronous reset.
  input  wire             in_valid,  // Source offers a word.
  input  wire [WIDTH-1:0] in_data,   // Offered word.
  output reg              in_ready,  // Room for a word.
  output wire             out_valid, // A word is held.
  output wire [WIDTH-1:0] out_data,  // Oldest word.
  input  wire             out_ready  // Sink takes the word.
);

  reg  [WIDTH-1:0] mem [0:DEPTH-1];
  reg  [AW-1:0]    wr_r;
  reg  [AW-1:0]    rd_r;
  reg  [AW:0]      count_r;
  reg  [AW:0]      count_nxt;
  wire             push;
  wire             pop;

  assign push      = in_valid & in_ready;
  assign pop       = out_valid & out_ready;
  assign out_valid = (count_r != {(AW+1){1'b0}});
  assign out_data  = mem[rd_r];

  always @*
  begin
    count_nxt = count_r;
    if (push & ~pop)
      count_nxt = count_r + 1'b1;
    else if (pop & ~push)
      count_nxt = count_r - 1'b1;
  end

  always @(posedge clock)
  begin
    if (push)
      mem[wr_r] <= in_data;
  end

  always @(posedge clock)
  begin
    if (rst)
    begin
      wr_r     <= {AW{1'b0}};
      rd_r     <= {AW{1'b0}};
      count_r  <= {(AW+1){1'b0}};
      in_ready <= 1'b0;
    end
    else
    begin
      if (push)
        wr_r <= (wr_r == DEPTH - 1) ? {AW{1'b0}} : wr_r + 1'b1;
      if (pop)
        rd_r <= (rd_r == DEPTH - 1) ? {AW{1'b0}} : rd_r + 1'b1;
      count_r  <= count_nxt;
      in_ready <= (count_nxt != DEPTH);
    end
  end

endmodule

// File: verification/ssp_checker.sv
// Assertions on the serial port core ports.
// Assumes the mode inputs latch only while both enables are low.
module ssp_checker (
  input wire logic clock,         // Clock.
  input wire logic rst,           // Reset.
  input wire logic sio_en,        // Port enable.
  input wire logic tx_en,         // Tx enable.
  input wire logic rx_en,         // Rx enable.
  input wire logic sync_mode,     // Mode.
  input wire logic ext_clk_sel,   // Clock source.
  input wire logic rdy_out_en,    // Ready enable.
  input wire logic tx_valid,      // Byte offered.
  input wire logic tx_ready,      // Queue room.
  input wire logic rx_valid,      // Byte received.
  input wire logic tx_shift_done, // Shift done.
  input wire logic tx_buf_empty,  // Buffer empty.
  input wire logic sclk_oe,       // Clock pin on.
  input wire logic txd_oe,        // Data pin on.
  input wire logic serial_receive_ready_out_oe        // Ready pin on.
);
  timeunit 1ns;
  timeprecision 100ps;
  logic sync_r;
  logic ext_r;
  always_ff @(posedge clock)
  begin
    if (rst)
    begin
      sync_r <= 1'b0;
      ext_r  <= 1'b0;
    end
    else if (!tx_en && !rx_en)
    begin
      sync_r <= sync_mode;
      ext_r  <= ext_clk_sel;
    end
  end
  default clocking cb @(posedge clock);
  endclocking
  default disable iff (rst);
  sequence s_tx_off;
    (!tx_en && !rx_en) [*4];
  endsequence
  property p_tx_off;
    s_tx_off |-> tx_shift_done && tx_buf_empty;
  endproperty
  property p_txd_oe;
    !$past(rst) |-> txd_oe == $past(sio_en);
  endproperty
  property p_pins_off;
    !$past(rst) && !$past(sio_en) |-> !sclk_oe && !serial_receive_ready_out_oe;
  endproperty
  property p_serial_receive_ready_out;
    serial_receive_ready_out_oe |-> $past(sio_en && tx_en && rx_en && rdy_out_en && sync_r && ext_r);
  endproperty
  property p_done_fall;
    $fell(tx_shift_done) |-> $past(tx_en || rx_en);
  endproperty
  property p_rx_en;
    rx_valid |-> $past(rx_en);
  endproperty
  property p_sync_rx;
    rx_valid && sync_r |-> $past(sio_en);
  endproperty
  property p_sclk_oe;
    sclk_oe |-> $past(sio_en && sync_r && !ext_r);
  endproperty
  property p_fifo;
    $fell(tx_ready) |-> $past(tx_valid);
  endproperty
  a_tx_off: assert property (p_tx_off) else $error("tx not reset");
  a_txd_oe: assert property (p_txd_oe) else $error("txd_oe wrong");
  a_pins_off: assert property (p_pins_off) else $error("pin driven");
  a_serial_receive_ready_out: assert property (p_serial_receive_ready_out) else $error("serial_receive_ready_out_oe wrong");
  a_done_fall: assert property (p_done_fall) else $error("done fell idle");
  a_rx_en: assert property (p_rx_en) else $error("rx while off");
  a_sync_rx: assert property (p_sync_rx) else $error("sync rx off");
  a_sclk_oe: assert property (p_sclk_oe) else $error("sclk_oe wrong");
  a_fifo: assert property (p_fifo) else $error("ready fell");
endmodule

bind ssp_core ssp_checker ssp_checker_inst (.*);

// File: verification/ssp_peer.sv
// Serial peer: external shift clock source and UART sender.
// Assumes the bench resolves the pin wires; the transmit wire is pulled high.
module ssp_peer #(
  parameter real HALF_NS = 62.5,
  parameter real BIT_NS  = 64.0
) (
  input  wire logic txd_pin, // Transmit wire.
  output logic      rxd,     // Receive data.
  output logic      sclk     // Shift clock.
);
  timeunit 1ns;
  timeprecision 100ps;
  logic [7:0] uart_got;
  initial
  begin
    rxd  = 1'b1;
    sclk = 1'b1;
  end
  // Captures each UART frame seen on the transmit wire, sampling mid-bit.
  initial
  begin
    uart_got = 8'h00;
    forever
    begin
      @(negedge txd_pin);
      #(BIT_NS * 1.5);
      for (int i = 0; i < 8; i++)
      begin
        uart_got[i] = txd_pin;
        #(BIT_NS);
      end
    end
  end
  task automatic uart_send(input logic [7:0] b, input logic stop);
    logic [9:0] f;
    f = {stop, b, 1'b0};
    for (int i = 0; i < 10; i++)
    begin
      rxd = f[i];
      #(BIT_NS);
    end
    rxd = 1'b1;
  endtask
  // The clock stands high between frames; released data floats high.
  task automatic sync_xfer(input logic [7:0] b, output logic [7:0] got);
    for (int i = 0; i < 8; i++)
    begin
      sclk = 1'b0;
      rxd  = b[i];
      #(HALF_NS);
      sclk   = 1'b1;
      got[i] = txd_pin;
      #(HALF_NS);
    end
    rxd = 1'b1;
  endtask
endmodule

// File: verification/ssp_core_tb.sv
// Bench for the serial port core: transfer table, then edge cases.
// Assumes the peer drives the link pins and the checker is bound in.
module ssp_core_tb;
  timeunit 1ns;
  timeprecision 100ps;
  typedef struct packed {logic sm; logic txe; logic rxe; logic [7:0] txb; logic [7:0] rxb;} ssp_row_t;
  ssp_row_t rows [6] = '{{3'h7, 8'hA5, 8'h3C}, {3'h7, 8'h01, 8'h80}, {3'h5, 8'h00, 8'hC3},
                         {3'h1, 8'h00, 8'h5A}, {3'h3, 8'h81, 8'hFF}, {3'h2, 8'h7E, 8'h00}};
  logic       clock, rst, sio_en, tx_en, rx_en, sync_mode, ext_clk_sel, tx_valid;
  logic       rdy_out_en, err_clr;
  logic [7:0] tx_data, rx_last, got;
  wire        tx_ready, rx_valid, frame_err, tx_shift_done, tx_buf_empty, rdy;
  wire        sclk_out, sclk_oe, txd_out, txd_oe, serial_receive_ready_out_oe, rxd, peer_sclk;
  wire [7:0]  rx_data;
  int         num_errors = 0, compares = 0, cycles = 0, rx_cnt = 0, pin_cnt = 0, i, acc;
  int         sclk_low = 0, txd_low = 0;
  wire        txd_pin  = txd_oe ? txd_out : 1'b1;
  wire        sclk_pin = sclk_oe ? sclk_out : peer_sclk;
  ssp_core ssp_core_inst (.clock(clock), .rst(rst), .sio_en(sio_en), .tx_en(tx_en),
    .rx_en(rx_en), .sync_mode(sync_mode), .ext_clk_sel(ext_clk_sel), .rdy_out_en(rdy_out_en),
    .baud_div(12'h003), .err_clr(err_clr), .tx_valid(tx_valid), .tx_data(tx_data),
    .tx_ready(tx_ready), .rx_valid(rx_valid), .rx_data(rx_data), .frame_err(frame_err),
    .tx_shift_done(tx_shift_done), .tx_buf_empty(tx_buf_empty), .rxd_pin(rxd),
    .sclk_pin(sclk_pin), .sclk_out(sclk_out), .sclk_oe(sclk_oe), .txd_out(txd_out),
    .txd_oe(txd_oe), .serial_receive_ready_out(rdy), .serial_receive_ready_out_oe(serial_receive_ready_out_oe));
  ssp_peer ssp_peer_inst (.txd_pin(txd_pin), .rxd(rxd), .sclk(peer_sclk));
  initial
  begin
    clock = 1'b0;
    forever #4 clock = ~clock;
  end
  task automatic summarize();
    if (num_errors == 0 && compares > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask
  always @(posedge clock)
  begin
    cycles <= cycles + 1;
    if (rx_valid === 1'b1)
    begin
      rx_cnt  <= rx_cnt + 1;
      rx_last <= rx_data;
    end
    if (txd_oe === 1'b1 || sclk_oe === 1'b1)
      pin_cnt <= pin_cnt + 1;
    if (sclk_oe === 1'b1 && sclk_out === 1'b0)
      sclk_low <= sclk_low + 1;
    if (txd_oe === 1'b1 && txd_out === 1'b0)
      txd_low <= txd_low + 1;
    if (cycles == 10000)
    begin
      num_errors++;
      summarize();
    end
  end
  task automatic chk(input logic ok, input string msg);
    compares++;
    if (ok !== 1'b1)
    begin
      num_errors++;
      $display("[ERR] %0t %s", $time, msg);
    end
  endtask
  task automatic cyc(input int n);
    repeat (n) @(posedge clock);
  endtask
  task automatic set_mode(input logic s, input logic e);
    sio_en <= 1'b0;
    tx_en  <= 1'b0;
    rx_en  <= 1'b0;
    cyc(3);
    sync_mode   <= s;
    ext_clk_sel <= e;
    cyc(3);
  endtask
  task automatic push(input logic [7:0] b);
    int n;
    n = 0;
    tx_valid <= 1'b1;
    tx_data  <= b;
    do
    begin
      @(posedge clock);
      n++;
    end
    while (tx_ready !== 1'b1 && n < 50);
    tx_valid <= 1'b0;
  endtask
  task automatic wait_done(input logic v, input int lim);
    int n;
    n = 0;
    while (tx_shift_done !== v && n < lim)
    begin
      @(posedge clock);
      n++;
    end
    chk(tx_shift_done === v, "completion flag stuck");
  endtask
  task automatic reset_dut(input int n);
    rst <= 1'b1;
    cyc(n);
    rst <= 1'b0;
    cyc(2);
    chk({tx_shift_done, tx_buf_empty, txd_out, txd_oe, sclk_oe, serial_receive_ready_out_oe, rx_valid, frame_err,
         tx_ready} === 9'h1C1, "reset values wrong");
  endtask
  initial
  begin
    {sio_en, tx_en, rx_en, sync_mode, ext_clk_sel, tx_valid, err_clr} = 7'h00;
    rdy_out_en = 1'b1;
    tx_data = 8'h00;
    reset_dut(20);
    foreach (rows[k])
    begin
      set_mode(rows[k].sm, rows[k].sm);
      sio_en <= 1'b1;
      tx_en  <= rows[k].txe;
      rx_en  <= rows[k].rxe;
      i = rx_cnt;
      cyc(4);
      if (rows[k].txe)
        push(rows[k].txb);
      cyc(20);
      chk(serial_receive_ready_out_oe === (rows[k].sm & rows[k].txe & rows[k].rxe), "serial_receive_ready_out enable wrong");
      chk(rdy === (rows[k].sm & rows[k].txe & rows[k].rxe), "ready level wrong");
      if (rows[k].sm)
        ssp_peer_inst.sync_xfer(rows[k].rxb, got);
      else
        ssp_peer_inst.uart_send(rows[k].rxb, 1'b1);
      cyc(13);
      chk(rx_cnt == i + int'(rows[k].rxe), "receive count wrong");
      chk(!rows[k].rxe || rx_last === rows[k].rxb, "received byte wrong");
      chk(!rows[k].sm || !rows[k].txe || got === rows[k].txb, "sent byte wrong");
      chk(rows[k].sm || !rows[k].txe || ssp_peer_inst.uart_got === rows[k].txb,
          "uart byte wrong");
      chk(frame_err === 1'b0, "framing error");
    end
    rx_en <= 1'b1;
    cyc(4);
    ssp_peer_inst.uart_send(8'h33, 1'b0);
    cyc(13);
    chk(frame_err === 1'b1 && rx_last === 8'h33, "stop error not flagged");
    err_clr <= 1'b1;
    cyc(1);
    err_clr <= 1'b0;
    cyc(2);
    chk(frame_err === 1'b0, "stop error not cleared");
    set_mode(1'b1, 1'b1);
    {sio_en, tx_en, rx_en} <= 3'h7;
    rdy_out_en <= 1'b0;
    cyc(4);
    chk(serial_receive_ready_out_oe === 1'b0 && rdy === 1'b0, "ready driven while off");
    rdy_out_en <= 1'b1;
    cyc(3);
    chk(serial_receive_ready_out_oe === 1'b1 && rdy === 1'b1, "ready not driven");
    set_mode(1'b1, 1'b0);
    tx_en <= 1'b1;
    cyc(4);
    i = pin_cnt;
    push(8'h96);
    wait_done(1'b0, 40);
    wait_done(1'b1, 200);
    chk(pin_cnt == i, "pins driven while disabled");
    push(8'h69);
    wait_done(1'b0, 40);
    cyc(10);
    sio_en <= 1'b1;
    cyc(3);
    chk(txd_oe === 1'b1 && sclk_oe === 1'b1, "pins not driven mid byte");
    i   = sclk_low;
    acc = txd_low;
    wait_done(1'b1, 200);
    chk(sclk_low > i && txd_low > acc, "remaining bits not shown");
    set_mode(1'b0, 1'b0);
    sio_en <= 1'b1;
    tx_en  <= 1'b1;
    cyc(4);
    push(8'h00);
    wait_done(1'b0, 40);
    sync_mode <= 1'b1;
    cyc(30);
    chk(sclk_oe === 1'b0, "mode changed while enabled");
    tx_en     <= 1'b0;
    sync_mode <= 1'b0;
    cyc(4);
    chk(tx_shift_done === 1'b1 && txd_out === 1'b1 && tx_buf_empty === 1'b1, "no abort");
    acc = 0;
    tx_valid <= 1'b1;
    tx_data  <= 8'h10;
    repeat (12)
    begin
      @(posedge clock);
      if (tx_ready === 1'b1)
      begin
        acc++;
        tx_data <= 8'h10 + acc[7:0];
      end
    end
    tx_valid <= 1'b0;
    chk(acc == 8 && tx_ready === 1'b0, "queue did not refuse at eight");
    tx_en <= 1'b1;
    wait_done(1'b0, 40);
    wait_done(1'b1, 1000);
    chk(tx_ready === 1'b1 && tx_buf_empty === 1'b1, "queue did not drain");
    set_mode(1'b0, 1'b0);
    reset_dut(3);
    summarize();
  end
endmodule
